// ==== core/erase_and_identify_cmd.sv ====
// Purpose: Card-side handling of the sector pre-erase and identify
//          commands behind the task file.
// Assumes: Host strobes are synchronous to MCLK and one cycle long.
// Notes:   Geometry and strings are elaboration-time parameters.
`timescale 1ns/10ps
`include "eic_consts.svh"

// Summary of operation
// - Erase code starts a media pre-erase; no data; may end in write fault.
// - Identify code returns the block like a single-sector read.
// - Reserved bits and words of the block read as zero.
// - Word 0 is default value, alternate value in IDE-compatible mode.
// - Words 1, 3, 6 give default cylinders, heads, sectors per track.
// - Words 7-8 give total sectors as a double word.
// - Serial text in words 10-19 is right-justified, space padded.
// - Model text in words 27-46 is left-justified, space padded.
// - Word 47 gives most sectors per interrupt for multiple commands.
// - Capabilities: bit 13 zero, bit 9 LBA, bit 8 DMA support.
// - Word 51 upper byte reports legacy PIO mode two.
// - Word 53 bits 1 and 0 mark words 64-70 and 54-58 valid.
// - Words 54-56 current geometry, words 57-58 their product.
// - Word 59: bits 15-9 zero, bit 8 one, low byte zero or one.
// - Words 60-61 give sectors addressable in LBA mode.
// - Word 63 upper byte marks at most one selected DMA mode.
// - Word 63 low byte flags supported DMA modes, bits 7-3 zero.
// - Word 64 flags PIO modes 4 and 3; bits 7-2 zero.
// - Words 65 to 68 each return 50h.
// - Word 163 reports 2h in bits 2-0 and bits 5-3.
// - Word 163 bits 8-6 and 11-9 give selected advanced modes.
// - Busy rises within 400 ns of an erase or identify code write.
module erase_and_identify_cmd
	import eic_pkg::*;
#(
	parameter logic [15:0]  CYLS      = 16'h03d4,
	parameter logic [15:0]  HEADS     = 16'h0010,
	parameter logic [15:0]  SPT       = 16'h0020,
	parameter logic         DMA_SUP   = 1'b0,
	parameter logic [159:0] SERIAL    = "0000000001",
	parameter logic [319:0] MODEL     = "STORAGE CARD",
	parameter logic [63:0]  FIRMWARE  = "REV 1.0"
) (
	input  wire logic       MCLK,
	input  wire logic       RST_N,
	input  wire logic       CE,
	input  wire tf_req_t    TF_REQ,
	output logic [15:0]     TF_RDATA,
	input  wire logic       IDE_MODE,
	input  wire logic       MULT_SET,
	input  wire logic [1:0] DMA_SEL,
	input  wire logic [2:0] ADV_PIO_SEL,
	input  wire logic [2:0] ADV_DMA_SEL,
	output logic            ERASE_REQ,
	output erase_cmd_t      ERASE_CMD,
	input  wire logic       ERASE_DONE,
	input  wire logic       ERASE_FAULT,
	output logic            BUSY,
	output logic            DRQ
);

	// -------------------------------------------------------------------
	// Elaboration-time text shaping
	// -------------------------------------------------------------------
	// Zero bytes left of the text become spaces, text stays at the right
	function automatic logic [159:0] rjust(input logic [159:0] s);
		logic [159:0] t;
		t = s;
		for (int i = 0; i < 20; i++) begin
			if (t[i*8 +: 8] == 8'h00)
				t[i*8 +: 8] = `SPACE_CODE;
		end
		return t;
	endfunction

	// Short literals pad on the left, so shift text up to the first byte
	function automatic logic [319:0] ljust(input logic [319:0] s);
		logic [319:0] t;
		t = s;
		for (int i = 0; i < 40; i++) begin
			if (t[319:312] == 8'h00 && t != '0)
				t = {t[311:0], `SPACE_CODE};
		end
		for (int i = 0; i < 40; i++) begin
			if (t[i*8 +: 8] == 8'h00)
				t[i*8 +: 8] = `SPACE_CODE;
		end
		return t;
	endfunction

	localparam logic [159:0] SER_TXT = rjust(SERIAL);
	localparam logic [319:0] MOD_TXT = ljust(MODEL);
	localparam logic [31:0]  TOTAL   = 32'(CYLS) * 32'(HEADS) * 32'(SPT);
	localparam int           BUSY_CYC_I = `BUSY_CYC;

	// -------------------------------------------------------------------
	// Task file registers
	// -------------------------------------------------------------------
	state_t      state_r;
	logic [7:0]  feature_reg;
	logic [7:0]  sector_count_reg;
	logic [7:0]  sector_number_reg;
	logic [7:0]  cylinder_low_reg;
	logic [7:0]  cylinder_high_reg;
	logic [7:0]  drive_head_reg;
	logic [7:0]  idx_r;
	logic        busy_r;
	logic        drq_r;
	logic        err_r;
	logic        fault_r;
	logic        abort_r;
	logic        ereq_r;
	logic [15:0] rdata_r;
	logic [15:0] word;
	logic [7:0]  status;
	logic        cmd_wr;
	logic        cmd_ok;
	logic        dat_rd;

	assign cmd_wr = CE && TF_REQ.wr && TF_REQ.addr == `OFS_COMMAND;
	// writes while busy
	// A command written during busy or a data phase is dropped
	assign cmd_ok = cmd_wr && !busy_r && !drq_r;
	assign dat_rd = CE && TF_REQ.rd && TF_REQ.addr == `OFS_DATA
		&& state_r == ST_IDXFER;

	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			feature_reg       <= `RST_BYTE;
			sector_count_reg  <= `RST_BYTE;
			sector_number_reg <= `RST_BYTE;
			cylinder_low_reg  <= `RST_BYTE;
			cylinder_high_reg <= `RST_BYTE;
			drive_head_reg    <= `RST_BYTE;
		end else if (CE && TF_REQ.wr && !busy_r) begin
			case (TF_REQ.addr)
			`OFS_FEATURE:  feature_reg       <= TF_REQ.wdata;
			`OFS_SECTOR_COUNT:  sector_count_reg  <= TF_REQ.wdata;
			`OFS_SECTOR_NUMBER: sector_number_reg <= TF_REQ.wdata;
			`OFS_CYLINDER_LOW:  cylinder_low_reg  <= TF_REQ.wdata;
			`OFS_CYLINDER_HIGH: cylinder_high_reg <= TF_REQ.wdata;
			`OFS_DRV_HEAD: drive_head_reg    <= TF_REQ.wdata;
			default: ;
			endcase
		end
	end

	// -------------------------------------------------------------------
	// Command sequencer
	// -------------------------------------------------------------------
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			state_r <= ST_IDLE;
			busy_r  <= 1'b0;
			drq_r   <= 1'b0;
			idx_r   <= 8'h00;
			ereq_r  <= 1'b0;
		end else if (CE) begin
			ereq_r <= 1'b0;
			case (state_r)
			ST_IDLE: begin
				if (cmd_ok && (TF_REQ.wdata == `CMD_ERASE
					|| TF_REQ.wdata == `CMD_IDENTIFY)) begin
					busy_r  <= 1'b1;
					state_r <= (TF_REQ.wdata == `CMD_ERASE)
						? ST_ERREQ : ST_IDPREP;
				end
			end
			ST_IDPREP: begin
				busy_r  <= 1'b0;
				drq_r   <= 1'b1;
				idx_r   <= 8'h00;
				state_r <= ST_IDXFER;
			end
			ST_IDXFER: begin
				if (dat_rd) begin
					idx_r <= idx_r + 8'h01;
					if (idx_r == `LAST_WORD) begin
						drq_r   <= 1'b0;
						state_r <= ST_IDLE;
					end
				end
			end
			ST_ERREQ: begin
				ereq_r  <= 1'b1;
				state_r <= ST_ERWAIT;
			end
			ST_ERWAIT: begin
				if (ERASE_DONE) begin
					busy_r  <= 1'b0;
					state_r <= ST_IDLE;
				end
			end
			default: begin
				state_r <= ST_IDLE;
				busy_r  <= 1'b0;
				drq_r   <= 1'b0;
			end
			endcase
		end
	end

	// Error flags reloaded by the next accepted command: cleared for erase or identify, abort and error set for any other code
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			err_r   <= 1'b0;
			fault_r <= 1'b0;
			abort_r <= 1'b0;
		end else if (CE) begin
			if (cmd_ok) begin
				abort_r <= TF_REQ.wdata != `CMD_ERASE
					&& TF_REQ.wdata != `CMD_IDENTIFY;
				err_r   <= TF_REQ.wdata != `CMD_ERASE
					&& TF_REQ.wdata != `CMD_IDENTIFY;
				fault_r <= 1'b0;
			end else if (state_r == ST_ERWAIT && ERASE_DONE
				&& ERASE_FAULT) begin
				err_r   <= 1'b1;
				fault_r <= 1'b1;
			end
		end
	end

	// -------------------------------------------------------------------
	// Parameter block word
	// -------------------------------------------------------------------
	always_comb begin
		word = 16'h0000;
		case (idx_r)
		8'd0:  word = IDE_MODE ? `W0_ALTERNATE : `W0_DEFAULT;
		8'd1:  word = CYLS;
		8'd3:  word = HEADS;
		8'd6:  word = SPT;
		8'd7:  word = TOTAL[31:16];
		8'd8:  word = TOTAL[15:0];
		8'd47: word = `W47_VALUE;
		8'd49: word = `W49_LBA | (DMA_SUP ? `W49_DMA : 16'h0000);
		8'd51: word = `W51_VALUE;
		8'd53: word = `W53_VALUE;
		8'd54: word = CYLS;
		8'd55: word = HEADS;
		8'd56: word = SPT;
		8'd57: word = TOTAL[15:0];
		8'd58: word = TOTAL[31:16];
		8'd59: word = `W59_VALID | {15'h0000, MULT_SET};
		8'd60: word = TOTAL[15:0];
		8'd61: word = TOTAL[31:16];
		8'd63: word = {5'h00,
			DMA_SEL == 2'd3, DMA_SEL == 2'd2, DMA_SEL == 2'd1,
			`W63_SUPPORT};
		8'd64: word = `W64_VALUE;
		8'd65, 8'd66, 8'd67, 8'd68: word = `W65_CYCLE;
		8'd163: word = {4'h0, ADV_DMA_SEL, ADV_PIO_SEL,
			`W163_DMA_MAX, `W163_PIO_MAX};
		default: begin
			if (idx_r >= 8'd10 && idx_r <= 8'd19)
				word = SER_TXT[159 - 16*(idx_r - 8'd10) -: 16];
			// Firmware text, high byte first
			else if (idx_r >= 8'd23 && idx_r <= 8'd26)
				word = FIRMWARE[63 - 16*(idx_r - 8'd23) -: 16];
			else if (idx_r >= 8'd27 && idx_r <= 8'd46)
				word = MOD_TXT[319 - 16*(idx_r - 8'd27) -: 16];
		end
		endcase
	end

	// -------------------------------------------------------------------
	// Read path and outputs
	// -------------------------------------------------------------------
	assign status = {busy_r, 1'b1, fault_r, 1'b1, drq_r, 2'b00, err_r};

	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			rdata_r <= 16'h0000;
		end else if (CE && TF_REQ.rd) begin
			case (TF_REQ.addr)
			`OFS_DATA:     rdata_r <= dat_rd ? word : 16'h0000;
			`OFS_FEATURE:  rdata_r <= {13'h0000, abort_r, 2'b00};
			`OFS_SECTOR_COUNT:  rdata_r <= {8'h00, sector_count_reg};
			`OFS_SECTOR_NUMBER: rdata_r <= {8'h00, sector_number_reg};
			`OFS_CYLINDER_LOW:  rdata_r <= {8'h00, cylinder_low_reg};
			`OFS_CYLINDER_HIGH: rdata_r <= {8'h00, cylinder_high_reg};
			`OFS_DRV_HEAD: rdata_r <= {8'h00, drive_head_reg};
			default:       rdata_r <= {8'h00, status};
			endcase
		end
	end

	assign TF_RDATA = rdata_r;
	assign BUSY     = busy_r;
	assign DRQ      = drq_r;
	assign ERASE_REQ = ereq_r;
	assign ERASE_CMD.lba_mode = drive_head_reg[`DH_LBA_BIT];
	assign ERASE_CMD.addr  = {drive_head_reg[3:0], cylinder_high_reg,
		cylinder_low_reg, sector_number_reg};
	assign ERASE_CMD.count = sector_count_reg;

	// -------------------------------------------------------------------
	// Assertions
	// -------------------------------------------------------------------
	default clocking cb @(posedge MCLK); endclocking
	default disable iff (!RST_N);

	chk_busy_rise: assert property (
		cmd_ok && (TF_REQ.wdata == `CMD_IDENTIFY
		|| TF_REQ.wdata == `CMD_ERASE)
		|-> ##[1:BUSY_CYC_I] busy_r)
		else $error("busy not raised after command");
	chk_id_phase: assert property (
		state_r == ST_IDPREP && CE |=> drq_r && !busy_r && idx_r == 8'h00)
		else $error("identify data phase not entered");
	chk_word_walk: assert property (
		$fell(drq_r) |-> $past(idx_r) == `LAST_WORD && idx_r == 8'h00)
		else $error("data phase ended before last word");
	chk_idx_step: assert property (
		dat_rd |=> idx_r == $past(idx_r) + 8'h01)
		else $error("word index did not advance");
	chk_reserved_zero: assert property (
		idx_r == 8'd2 || idx_r == 8'd50 || idx_r == 8'd62 |-> word == 0)
		else $error("reserved word not zero");
	chk_config_word: assert property (
		idx_r == 8'd0 |-> word == (IDE_MODE ? `W0_ALTERNATE : `W0_DEFAULT)
		&& word[6] == IDE_MODE)
		else $error("configuration word wrong");
	chk_multi_set: assert property (
		idx_r == 8'd59 |-> word[15:9] == 7'h00 && word[8]
		&& word[7:1] == 7'h00)
		else $error("multiple sector word wrong");
	chk_dma_sel: assert property (
		idx_r == 8'd63 |-> $onehot0(word[15:8]) && word[7:3] == 5'h00)
		else $error("dma mode word wrong");
	chk_cycle_time: assert property (
		idx_r >= 8'd65 && idx_r <= 8'd68 |-> word == 16'h0050)
		else $error("cycle time word wrong");
	chk_adv_modes: assert property (
		idx_r == 8'd163 |-> word[5:0] == 6'h12
		&& word[8:6] == ADV_PIO_SEL && word[11:9] == ADV_DMA_SEL)
		else $error("advanced mode word wrong");
	chk_erase_req: assert property (
		cmd_ok && TF_REQ.wdata == `CMD_ERASE
		|-> ##2 ERASE_REQ ##1 !ERASE_REQ)
		else $error("erase request not pulsed");
	chk_erase_fault: assert property (
		CE && state_r == ST_ERWAIT && ERASE_DONE && ERASE_FAULT
		|=> err_r && fault_r && !busy_r && !drq_r)
		else $error("write fault not reported");
	chk_no_cmd_busy: assert property (
		cmd_wr && busy_r |=> $stable(state_r))
		else $error("command taken while busy");

	cov_identify: cover property (
		state_r == ST_IDXFER && dat_rd && idx_r == `LAST_WORD);
	cov_erase_ok: cover property (
		state_r == ST_ERWAIT && ERASE_DONE && !ERASE_FAULT);
	cov_erase_fault: cover property (
		state_r == ST_ERWAIT && ERASE_DONE && ERASE_FAULT);
	cov_abort: cover property (cmd_ok ##1 abort_r);

endmodule

// ==== core/eic_consts.svh ====
// Purpose: Offsets, codes, field positions and counts for the erase and
//          identify command block.
// Assumes: 100 MHz MCLK.
// Notes:   Definitions only.
`ifndef EIC_CONSTS_SVH
`define EIC_CONSTS_SVH
// -------------------------------------------------------------------
// Task file offsets
// -------------------------------------------------------------------
`define OFS_DATA       3'h0
`define OFS_FEATURE    3'h1
`define OFS_SECTOR_COUNT  3'h2
`define OFS_SECTOR_NUMBER 3'h3
`define OFS_CYLINDER_LOW  3'h4
`define OFS_CYLINDER_HIGH 3'h5
`define OFS_DRV_HEAD   3'h6
`define OFS_COMMAND    3'h7
// -------------------------------------------------------------------
// Command codes and field positions
// -------------------------------------------------------------------
`define CMD_ERASE      8'hc0
`define CMD_IDENTIFY   8'hec
`define DH_LBA_BIT     6
`define ERRB_ABORT     2
`define RST_BYTE       8'h00
// -------------------------------------------------------------------
// Parameter block contents
// -------------------------------------------------------------------
`define BLK_WORDS      9'h100
`define LAST_WORD      8'hff
// Arbitrary signature values; bit 6 set marks a fixed card
`define W0_DEFAULT     16'h8c00
`define W0_ALTERNATE   16'h0c40
`define W47_VALUE      16'h0001
`define W49_LBA        16'h0200
`define W49_DMA        16'h0100
`define W51_VALUE      16'h0200
`define W53_VALUE      16'h0003
`define W59_VALID      16'h0100
`define W63_SUPPORT    8'h07
`define W64_VALUE      16'h0003
`define W65_CYCLE      16'h0050
`define W163_PIO_MAX   3'h2
`define W163_DMA_MAX   3'h2
`define SPACE_CODE     8'h20
// -------------------------------------------------------------------
// Timing
// -------------------------------------------------------------------
`define CLK_PERIOD_NS  10
`define BUSY_MAX_NS    400
`define BUSY_CYC       (`BUSY_MAX_NS / `CLK_PERIOD_NS)
`endif

// ==== core/eic_pkg.sv ====
// Purpose: Types shared by the erase and identify command block.
// Assumes: Nothing beyond the constants header.
// Notes:   Structs carry grouped signals.
package eic_pkg;
	typedef enum logic [2:0] {
		ST_IDLE   = 3'b000,
		ST_IDPREP = 3'b001,
		ST_IDXFER = 3'b010,
		ST_ERREQ  = 3'b011,
		ST_ERWAIT = 3'b100
	} state_t;

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [2:0] addr;
		logic [7:0] wdata;
	} tf_req_t;

	typedef struct packed {
		logic        lba_mode;
		logic [27:0] addr;
		logic [7:0]  count;
	} erase_cmd_t;
endpackage

// ==== dv/host_model.sv ====
// Purpose: Host side of the task file: byte writes, word reads, commands.
// Assumes: Strobes launched 1 ns after MCLK rise, one cycle long.
// Notes:   Tasks are called by hierarchy from the testbench.
`timescale 1ns/10ps
`include "eic_consts.svh"
module host_model
	import eic_pkg::*;
(
	input  wire logic        MCLK,
	input  wire logic        BUSY,
	input  wire logic        DRQ,
	input  wire logic [15:0] TF_RDATA,
	output tf_req_t          TF_REQ
);
	initial begin
		TF_REQ = '0;
	end

	// Released lines show inverted values so nothing stale looks valid
	task automatic access(input logic w, input logic [2:0] a,
		input logic [7:0] d);
		@(posedge MCLK);
		#1;
		TF_REQ = '{wr: w, rd: ~w, addr: a, wdata: d};
		@(posedge MCLK);
		#1;
		TF_REQ = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
	endtask

	task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
		access(1'b1, a, d);
	endtask

	// Answer registered at the taking edge, read 1 ns later
	task automatic rd_reg(input logic [2:0] a, output logic [15:0] d);
		access(1'b0, a, 8'h00);
		d = TF_RDATA;
	endtask

	task automatic send_cmd(input logic [7:0] c);
		int n;
		n = 0;
		while ((BUSY !== 1'b0 || DRQ !== 1'b0) && n < 1000) begin
			@(posedge MCLK);
			n++;
		end
		wr_reg(`OFS_COMMAND, c);
	endtask
endmodule

// ==== dv/testbench.sv ====
// Purpose: Self-checking bench for the erase and identify block.
// Assumes: 100 MHz MCLK, host model as task file partner.
// Notes:   Firmware words are not compared; their layout is free.
`timescale 1ns/10ps
`include "eic_consts.svh"
module testbench;
	import eic_pkg::*;
	typedef struct packed {
		logic        ide;
		logic        mult;
		logic [1:0]  dma;
		logic [2:0]  apio;
		logic [2:0]  adma;
		logic [15:0] w0;
		logic [15:0] w63;
	} mode_row_t;
	localparam logic [15:0]  CYL_P = 16'h0400;
	localparam logic [15:0]  HD_P  = 16'h0010;
	localparam logic [15:0]  SPT_P = 16'h0020;
	localparam logic [31:0]  TOTAL = 32'(CYL_P) * 32'(HD_P) * 32'(SPT_P);
	localparam logic [159:0] SER_X = {{16{8'h20}}, "SN42"};
	localparam logic [319:0] MDL_X = {"MDL X", {35{8'h20}}};
	mode_row_t   rows [4] = '{
		'{1'b1, 1'b1, 2'd0, 3'h1, 3'h4, `W0_ALTERNATE, 16'h0007},
		'{1'b0, 1'b0, 2'd1, 3'h6, 3'h1, `W0_DEFAULT, 16'h0107},
		'{1'b1, 1'b0, 2'd2, 3'h0, 3'h7, `W0_ALTERNATE, 16'h0207},
		'{1'b0, 1'b1, 2'd3, 3'h7, 3'h0, `W0_DEFAULT, 16'h0407}};
	logic        MCLK;
	logic        RST_N;
	logic        CE;
	logic        ERASE_DONE;
	logic        ERASE_FAULT;
	logic        ERASE_REQ;
	logic        BUSY;
	logic        DRQ;
	logic        fault_sel;
	logic [15:0] TF_RDATA;
	tf_req_t     TF_REQ;
	erase_cmd_t  ERASE_CMD;
	mode_row_t   cur;
	int          err_total;
	int          comparisons;

	erase_and_identify_cmd #(
		.CYLS    (CYL_P),
		.HEADS   (HD_P),
		.SPT     (SPT_P),
		.DMA_SUP (1'b1),
		.SERIAL  ("SN42"),
		.MODEL   ("MDL X")
	) i_dut (
		.MCLK        (MCLK),
		.RST_N       (RST_N),
		.CE          (CE),
		.TF_REQ      (TF_REQ),
		.TF_RDATA    (TF_RDATA),
		.IDE_MODE    (cur.ide),
		.MULT_SET    (cur.mult),
		.DMA_SEL     (cur.dma),
		.ADV_PIO_SEL (cur.apio),
		.ADV_DMA_SEL (cur.adma),
		.ERASE_REQ   (ERASE_REQ),
		.ERASE_CMD   (ERASE_CMD),
		.ERASE_DONE  (ERASE_DONE),
		.ERASE_FAULT (ERASE_FAULT),
		.BUSY        (BUSY),
		.DRQ         (DRQ)
	);

	host_model hm (
		.MCLK     (MCLK),
		.BUSY     (BUSY),
		.DRQ      (DRQ),
		.TF_RDATA (TF_RDATA),
		.TF_REQ   (TF_REQ)
	);

	always #5 MCLK = ~MCLK;

	// ---------------------------------------------------------------
	// Media side: slow erase, fault as the scenario asks
	// ---------------------------------------------------------------
	initial begin
		ERASE_DONE = 1'b0;
		ERASE_FAULT = 1'b0;
		forever begin
			@(posedge MCLK);
			#1;
			if (ERASE_REQ === 1'b1) begin
				repeat (20) @(posedge MCLK);
				#1;
				ERASE_DONE = 1'b1;
				ERASE_FAULT = fault_sel;
				@(posedge MCLK);
				#1;
				ERASE_DONE = 1'b0;
				ERASE_FAULT = ~fault_sel;
			end
		end
	end

	// ---------------------------------------------------------------
	// Checks and expectations
	// ---------------------------------------------------------------
	task automatic cmp_word(input string n, input logic [15:0] e,
		input logic [15:0] g);
		comparisons++;
		if (g !== e) begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic cmp_bit(input string n, input logic e, input logic g);
		cmp_word(n, {15'h0, e}, {15'h0, g});
	endtask

	function automatic logic [15:0] exp_word(input int i, input mode_row_t r);
		logic [15:0] w;
		w = 16'h0000;
		if (i >= 10 && i <= 19) w = SER_X[159 - 16 * (i - 10) -: 16];
		if (i >= 27 && i <= 46) w = MDL_X[319 - 16 * (i - 27) -: 16];
		if (i >= 65 && i <= 68) w = 16'h0050;
		case (i)
		0: w = r.w0;
		1, 54: w = CYL_P;
		3, 55: w = HD_P;
		6, 56: w = SPT_P;
		8, 57, 60: w = TOTAL[15:0];
		7, 58, 61: w = TOTAL[31:16];
		47: w = 16'h0001;
		49: w = 16'h0300;
		51: w = 16'h0200;
		53: w = 16'h0003;
		59: w = {15'h0080, r.mult};
		63: w = r.w63;
		64: w = 16'h0003;
		163: w = {4'h0, r.adma, r.apio, 3'h2, 3'h2};
		default: ;
		endcase
		return w;
	endfunction

	task automatic wait_busy();
		int n;
		n = 0;
		while (BUSY !== 1'b1 && n < 40) begin
			@(posedge MCLK);
			#1;
			n++;
		end
		cmp_bit("busy_rise", 1'b1, BUSY);
	endtask

	task automatic start_identify(input mode_row_t r);
		int n;
		cur = r;
		hm.send_cmd(`CMD_IDENTIFY);
		wait_busy();
		n = 0;
		while (DRQ !== 1'b1 && n < 40) begin
			@(posedge MCLK);
			#1;
			n++;
		end
		cmp_bit("drq_rise", 1'b1, DRQ);
	endtask

	task automatic do_identify(input mode_row_t r);
		logic [15:0] d;
		start_identify(r);
		for (int i = 0; i < 256; i++) begin
			hm.rd_reg(`OFS_DATA, d);
			if (i < 23 || i > 26)
				cmp_word("id_word", exp_word(i, r), d);
		end
		@(posedge MCLK);
		#1;
		cmp_bit("drq_end", 1'b0, DRQ);
	endtask

	task automatic do_erase(input logic [7:0] dh, input logic flt);
		logic [15:0] d;
		int n;
		hm.wr_reg(`OFS_DRV_HEAD, dh);
		hm.wr_reg(`OFS_CYLINDER_HIGH, 8'h12);
		hm.wr_reg(`OFS_CYLINDER_LOW, 8'h34);
		hm.wr_reg(`OFS_SECTOR_NUMBER, 8'h56);
		hm.wr_reg(`OFS_SECTOR_COUNT, 8'h5a);
		fault_sel = flt;
		hm.send_cmd(`CMD_ERASE);
		wait_busy();
		n = 0;
		while (ERASE_REQ !== 1'b1 && n < 40) begin
			@(posedge MCLK);
			#1;
			n++;
		end
		cmp_bit("erase_req", 1'b1, ERASE_REQ);
		cmp_word("erase_lo", 16'h3456, ERASE_CMD.addr[15:0]);
		cmp_word("erase_hi", {dh[6], dh[3:0], 8'h12, 3'h0},
			{ERASE_CMD.lba_mode, ERASE_CMD.addr[27:16], 3'h0});
		cmp_word("erase_cnt", 16'h005a, {8'h00, ERASE_CMD.count});
		// Both dropped while busy
		hm.wr_reg(`OFS_SECTOR_NUMBER, 8'haa);
		hm.wr_reg(`OFS_COMMAND, `CMD_IDENTIFY);
		n = 0;
		while (BUSY !== 1'b0 && n < 200) begin
			@(posedge MCLK);
			#1;
			n++;
		end
		hm.rd_reg(`OFS_SECTOR_NUMBER, d);
		cmp_word("sector_number", 16'h0056, d);
		hm.rd_reg(`OFS_COMMAND, d);
		cmp_word("status", flt ? 16'h0071 : 16'h0050, d);
	endtask

	task automatic end_sim();
		if (err_total == 0 && comparisons > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	initial begin
		#100000;
		err_total++;
		end_sim();
	end

	// ---------------------------------------------------------------
	// Main sequence
	// ---------------------------------------------------------------
	initial begin
		logic [15:0] d;
		err_total = 0;
		comparisons = 0;
		MCLK = 1'b0;
		RST_N = 1'b0;
		CE = 1'b1;
		fault_sel = 1'b0;
		cur = rows[0];
		repeat (5) @(posedge MCLK);
		cmp_bit("busy_rst", 1'b0, BUSY);
		cmp_bit("drq_rst", 1'b0, DRQ);
		cmp_word("rdata_rst", 16'h0000, TF_RDATA);
		#1;
		RST_N = 1'b1;
		foreach (rows[k]) do_identify(rows[k]);
		do_erase(8'he5, 1'b0);
		do_erase(8'ha3, 1'b1);
		// Unknown code: no busy, abort and error flags
		hm.send_cmd(8'h55);
		cmp_bit("busy_bad_cmd", 1'b0, BUSY);
		hm.rd_reg(`OFS_FEATURE, d);
		cmp_word("abort_flag", 16'h0004, d);
		hm.rd_reg(`OFS_COMMAND, d);
		cmp_word("status_abort", 16'h0051, d);
		// Enable low freezes the walk, then reset in mid-transfer
		start_identify(rows[1]);
		hm.rd_reg(`OFS_DATA, d);
		cmp_word("mid_word0", exp_word(0, rows[1]), d);
		CE = 1'b0;
		hm.rd_reg(`OFS_DATA, d);
		cmp_word("ce_hold", exp_word(0, rows[1]), d);
		CE = 1'b1;
		hm.rd_reg(`OFS_DATA, d);
		cmp_word("ce_resume", exp_word(1, rows[1]), d);
		RST_N = 1'b0;
		#2;
		cmp_bit("drq_mid_rst", 1'b0, DRQ);
		cmp_word("rdata_mid_rst", 16'h0000, TF_RDATA);
		@(posedge MCLK);
		#1;
		RST_N = 1'b1;
		do_identify(rows[2]);
		end_sim();
	end
endmodule
